// ---- rtl/cdr_read_path.sv ----
// serial slave read path of a character display: address match, write of
// address byte, read burst with prefetch on master acknowledge
// assumes scl/sda inputs already synchronous to mclk; memory loaded by mem_we
// Behaviour
// R01: each loaded byte is shifted out over 8 clock pulses, current address first.
// R02: a master acknowledge loads the next memory location into the shifter.
// R03: a missing acknowledge leaves shifter and data latch untouched.
// R04: a missing acknowledge leaves address counter and cursor unchanged.
// R05: the device releases the data line during the read acknowledge slot.
// R06: the host begins with function set selecting the 8-bit interface.
// R07: the host uses fixed waits, not the busy flag, in early initialisation.
// R08: the host waits 2 ms, repeats, then waits over 40 us.
// R09: read bytes go out top bit first.
// R10: during the read-address acknowledge the data latch goes to the shifter.
// R11: after a final unacknowledged byte a stop ends the transfer; the code already returns to idle at the clock fall that ends the nack slot.
`timescale 1ns/1ns
`include "cdr_map.svh"
module cdr_read_path #(
  parameter int ADDR_WIDTH = `CDR_ADDR_WIDTH,
  parameter int MEM_DEPTH  = `CDR_MEM_DEPTH
) (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  mem_we,
  input  wire logic [ADDR_WIDTH-1:0] mem_waddr,
  input  wire logic [7:0]            mem_wdata,
  output logic [ADDR_WIDTH-1:0]      address_counter,
  output logic [ADDR_WIDTH-1:0]      cursor_pos,
  output logic [7:0]                 internal_data_latch,
  output logic                       busy_flag
);
  cdr_pkg::cdr_state_type state;
  cdr_pkg::cdr_state_type next_state;
  logic [7:0]            shifter;
  logic [3:0]            bit_cnt;
  logic [7:0]            mem [MEM_DEPTH];
  logic                  ack_ok;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_seen;
  logic                  stop_seen;

  cdr_edge u_edge (
    .mclk       (mclk),
    .nrst       (nrst),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  function automatic logic [ADDR_WIDTH-1:0] inc_addr(input logic [ADDR_WIDTH-1:0] a);
    inc_addr = a + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
  endfunction : inc_addr

  wire logic       byte_done  = (bit_cnt == `CDR_BYTE_BITS);
  wire logic       addr_match = (shifter[7:1] == `CDR_SLAVE_ADDR);
  wire logic       rd_bit     = shifter[0];
  wire logic [7:0] next_mem   = mem[inc_addr(address_counter)];

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      cdr_pkg::st_idle:     next_state = state;
      cdr_pkg::st_addr:     if (scl_fall && byte_done) begin
        next_state = addr_match ? cdr_pkg::st_addr_ack : cdr_pkg::st_idle;
      end
      cdr_pkg::st_addr_ack: if (scl_fall) begin
        next_state = rd_bit ? cdr_pkg::st_rd : cdr_pkg::st_wr;
      end
      cdr_pkg::st_wr:       if (scl_fall && byte_done) begin
        next_state = cdr_pkg::st_wr_ack;
      end
      cdr_pkg::st_wr_ack:   if (scl_fall) begin
        next_state = cdr_pkg::st_wr;
      end
      cdr_pkg::st_rd:       if (scl_fall && byte_done) begin
        next_state = cdr_pkg::st_rd_ack;
      end
      // R11 end after nack
      cdr_pkg::st_rd_ack:   if (scl_fall) begin
        next_state = ack_ok ? cdr_pkg::st_rd : cdr_pkg::st_idle;
      end
      default:              next_state = cdr_pkg::st_idle;
    endcase
    if (stop_seen) begin
      next_state = cdr_pkg::st_idle;
    end
    if (start_seen) begin
      next_state = cdr_pkg::st_addr;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= cdr_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // bit counter and receive/transmit shifter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt             <= 4'h0;
      shifter             <= 8'h00;
      ack_ok              <= 1'b0;
      address_counter     <= '0;
      cursor_pos          <= '0;
      internal_data_latch <= 8'h00;
    end else if (start_seen) begin
      bit_cnt <= 4'h0;
    end else begin
      if (scl_rise && (state == cdr_pkg::st_addr || state == cdr_pkg::st_wr)) begin
        shifter <= {shifter[6:0], sda_in};
        bit_cnt <= bit_cnt + 4'h1;
      end
      // R01 R09 msb first
      if (scl_rise && state == cdr_pkg::st_rd) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (scl_fall && state == cdr_pkg::st_rd && !byte_done) begin
        shifter <= {shifter[6:0], 1'b0};
      end
      if (scl_rise && state == cdr_pkg::st_rd_ack) begin
        ack_ok <= ~sda_in;
      end
      if (scl_fall && byte_done) begin
        bit_cnt <= 4'h0;
      end
      // R10 latch to shifter
      if (scl_fall && state == cdr_pkg::st_addr_ack && rd_bit) begin
        shifter <= internal_data_latch;
      end
      // written byte sets the address counter
      if (scl_fall && state == cdr_pkg::st_wr_ack) begin
        address_counter <= shifter[ADDR_WIDTH-1:0];
        cursor_pos      <= shifter[ADDR_WIDTH-1:0];
        internal_data_latch <= mem[shifter[ADDR_WIDTH-1:0]];
      end
      // R02 prefetch on ack; R03 R04 nothing on nack
      if (scl_fall && state == cdr_pkg::st_rd_ack && ack_ok) begin
        shifter             <= next_mem;
        internal_data_latch <= next_mem;
        address_counter     <= inc_addr(address_counter);
        cursor_pos          <= inc_addr(cursor_pos);
      end
    end
  end

  // open drain: drive low only for a zero bit; next bit of shifter after this fall
  function automatic logic next_mem_bit();
    if (state == cdr_pkg::st_rd_ack) begin
      next_mem_bit = next_mem[7];
    end else if (state == cdr_pkg::st_addr_ack) begin
      next_mem_bit = internal_data_latch[7];
    end else begin
      next_mem_bit = shifter[6];
    end
  endfunction : next_mem_bit

  // data line driver; device releases line in read ack slot (R05)
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (scl_fall || start_seen || stop_seen) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      case (next_state)
        cdr_pkg::st_addr_ack,
        cdr_pkg::st_wr_ack: sda_oe <= 1'b1;
        cdr_pkg::st_rd:     sda_oe <= ~(next_mem_bit());
        default:            sda_oe <= 1'b0;
      endcase
    end
  end

  // busy whenever the next state is not idle; host ignores it early (R07)
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_flag <= 1'b0;
    end else begin
      busy_flag <= (next_state != cdr_pkg::st_idle);
    end
  end
endmodule : cdr_read_path

// ---- shared/cdr_map.svh ----
// constants for the display read-path block: slave address, bit counts
// assumes inclusion by bare name from design files
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH
`define CDR_SLAVE_ADDR     7'h3a
`define CDR_BYTE_BITS      4'h8
`define CDR_ADDR_WIDTH     7
`define CDR_MEM_DEPTH      128
`define CDR_FILT_LEN       2'h2
// host waits in early initialisation, in mclk cycles of 40 ns
`define CDR_INIT_WAIT_CYC  50000
`define CDR_INIT_GAP_CYC   1001
`endif

// ---- shared/cdr_pkg.sv ----
// types for the display read-path block
// assumes the map header holds the numbers
package cdr_pkg;
  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_addr   = 3'b001,
    st_addr_ack = 3'b010,
    st_wr     = 3'b011,
    st_wr_ack = 3'b100,
    st_rd     = 3'b101,
    st_rd_ack = 3'b110
  } cdr_state_type;
endpackage : cdr_pkg

// ---- rtl/cdr_edge.sv ----
// edge detector for the serial clock and data lines (start, stop, clock edges)
// assumes lines are synchronous to mclk
`timescale 1ns/1ns
module cdr_edge (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen
);
  logic scl_q;
  logic sda_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
endmodule : cdr_edge

// ---- verification/cdr_read_path_props.sv ----
// assertions on the read path ports
// assumes a bind from the bench top file
`timescale 1ns/1ns
module cdr_read_path_props #(
  parameter int ADDR_WIDTH = 7
) (
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic                  scl_in,
  input wire logic                  sda_in,
  input wire logic                  sda_oe,
  input wire logic                  busy_flag,
  input wire logic [ADDR_WIDTH-1:0] address_counter,
  input wire logic [ADDR_WIDTH-1:0] cursor_pos,
  input wire logic [7:0]            internal_data_latch
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // the drive may only move while the clock is low, so bits stay valid
  a_oe_holds_high: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("drive moved, clock high");
  a_count_on_low: assert property (
    $changed(address_counter) |-> !scl_in) else $error("counter moved, clock high");
  a_latch_in_xfer: assert property (
    $changed(internal_data_latch) |-> $past(busy_flag)) else $error("latch moved idle");
  a_count_in_xfer: assert property (
    $changed(address_counter) |-> $past(busy_flag)) else $error("counter moved idle");
  a_cursor_in_xfer: assert property (
    $changed(cursor_pos) |-> $past(busy_flag)) else $error("cursor moved idle");
  a_stop_ends: assert property (
    scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:4] !busy_flag) else $error("no end");
  a_idle_quiet: assert property (
    !busy_flag && !$past(busy_flag) |-> !sda_oe) else $error("drive while idle");
endmodule : cdr_read_path_props

// ---- verification/cdr_host.sv ----
// host model: bus master making the serial clock, pulling data low
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ns
module cdr_host (
  input  wire logic  mclk,
  input  wire logic  sda_in,
  output logic       scl_in,
  output logic       sda_low,
  output logic       got,
  output logic [7:0] res
);
  initial {scl_in, sda_low, got, res} = 11'h400;
  task automatic drive(input logic c, input logic l, input int n);
    scl_in = c;
    sda_low = l;
    repeat (n) @(negedge mclk);
  endtask : drive
  task automatic start;
    drive(scl_in, 1'b0, 2);
    drive(1'b1, 1'b0, 4);
    drive(1'b1, 1'b1, 4);
    drive(1'b0, 1'b1, 0);
  endtask : start
  task automatic stop;
    drive(1'b0, 1'b1, 4);
    drive(1'b1, 1'b1, 4);
    drive(1'b1, 1'b0, 4);
  endtask : stop
  // released slots leave the line to the device
  task automatic xfer(input logic [7:0] d, input logic a, input logic rd);
    logic [8:0] w;
    logic [8:0] q;
    w = {d, a};
    for (int i = 8; i >= 0; i--) begin
      drive(1'b0, sda_low, 1);
      drive(1'b0, !w[i], 3);
      drive(1'b1, !w[i], 2);
      q[i] = sda_in;
      drive(1'b1, !w[i], 2);
    end
    drive(1'b0, sda_low, 1);
    res = rd ? q[8:1] : {7'h00, q[0]};
    got = !got;
  endtask : xfer
endmodule : cdr_host

// ---- verification/tb_top.sv ----
// bench top: preloads display memory, then refused and read bursts
// assumes the host model owns the serial clock
`timescale 1ns/1ns
`include "cdr_map.svh"
module tb_top;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       mem_we = 1'b0;
  logic [6:0] mem_waddr = 7'h00;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] mem [`CDR_MEM_DEPTH];
  logic [7:0] exp_q [$];
  logic [7:0] internal_data_latch, res;
  logic [6:0] address_counter, cursor_pos, a;
  logic       scl_in, sda_low, got, sda_out, sda_oe, busy_flag;
  int         n_errors = 0, samples_checked = 0, cyc = 0;
  wire        sda_in = !((sda_oe && !sda_out) || sda_low);
  always #20 mclk = ~mclk;
  cdr_read_path i_cdr_read_path (
    .mclk                (mclk),
    .nrst                (nrst),
    .scl_in              (scl_in),
    .sda_in              (sda_in),
    .sda_out             (sda_out),
    .sda_oe              (sda_oe),
    .mem_we              (mem_we),
    .mem_waddr           (mem_waddr),
    .mem_wdata           (mem_wdata),
    .address_counter     (address_counter),
    .cursor_pos          (cursor_pos),
    .internal_data_latch (internal_data_latch),
    .busy_flag           (busy_flag)
  );
  cdr_host i_cdr_host (
    .mclk    (mclk),
    .sda_in  (sda_in),
    .scl_in  (scl_in),
    .sda_low (sda_low),
    .got     (got),
    .res     (res)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up;
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  always @(got) if (nrst) check(res, exp_q.pop_front());
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h4cf1));
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    for (int k = 0; k < `CDR_MEM_DEPTH; k++) begin
      mem[k] = 8'($urandom);
      {mem_we, mem_waddr, mem_wdata} = {1'b1, 7'(k), mem[k]};
      @(negedge mclk);
    end
    mem_we = 1'b0;
    // function set twice: write direction, upper nibble 0011, lower nibble ignored
    for (int n = 0; n < 2; n++) begin
      repeat (2) exp_q.push_back(8'h00);
      i_cdr_host.start();
      i_cdr_host.xfer({`CDR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b0);
      i_cdr_host.xfer({4'h3, 4'($urandom)}, 1'b1, 1'b0);
      i_cdr_host.stop();
      // fixed waits only, the busy flag is never polled
      repeat ((n == 0) ? `CDR_INIT_WAIT_CYC : `CDR_INIT_GAP_CYC) @(negedge mclk);
    end
    exp_q.push_back(8'h01);
    i_cdr_host.start();
    i_cdr_host.xfer(8'h24, 1'b1, 1'b0);
    i_cdr_host.stop();
    repeat (3) begin
      a = 7'($urandom_range(120));
      repeat (3) exp_q.push_back(8'h00);
      for (int k = 0; k < 4; k++) exp_q.push_back(mem[a + k]);
      i_cdr_host.start();
      i_cdr_host.xfer({`CDR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b0);
      i_cdr_host.xfer({1'b0, a}, 1'b1, 1'b0);
      i_cdr_host.start();
      i_cdr_host.xfer({`CDR_SLAVE_ADDR, 1'b1}, 1'b1, 1'b0);
      // acked reads prefetch, the last is left unacked
      for (int k = 0; k < 4; k++) i_cdr_host.xfer(8'hff, k == 3, 1'b1);
      i_cdr_host.stop();
      // only acked bytes step the counter
      check({1'b0, address_counter}, {1'b0, a + 7'd3});
      check({1'b0, cursor_pos}, {1'b0, a + 7'd3});
      check(internal_data_latch, mem[a + 3]);
      check({7'h00, busy_flag}, 8'h00);
      check({7'h00, sda_out}, 8'h00);
    end
    check(8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule : tb_top
bind cdr_read_path cdr_read_path_props #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (.*);
